// *** hw/waveform_auto_shutdown_control.v ***
// Auto-shutdown control for a complementary waveform generator, with an AXI4-Lite slave.
//
// What this block does
// - The shutdown flag is set by hardware on a shutdown event, cleared by hardware on restart, reads one while shutdown holds and resets to zero.
// - The restart enable bit lets the outputs restart on their own once the cause has gone, and stops that when cleared.
// - On shutdown the B and D outputs follow their field: 11 drives one, 10 drives zero, 01 tri-states.
// - On shutdown the A and C outputs follow their own field with the same three codes.
// - A field of 00 drives that pair to its polarity-adjusted inactive level once the dead-band interval has passed.
// - After the flag clears the outputs stay in shutdown until the next rising edge of the data input.
// - The push-pull sequencer is reset while the generator is disabled or a shutdown event occurs.
`timescale 1ns/10ps
`default_nettype none
`include "shutdown_defines.vh"
module waveform_auto_shutdown_control #(
  parameter DEADBAND_CYCLES = (`DEADBAND_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
  input  wire        core_clk,
  input  wire        reset,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  output reg  [1:0]  s_axi_bresp,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  input  wire [3:0]  s_axi_araddr,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  input  wire        gen_data_in,
  input  wire        shutdown_event,
  output reg         output_a,
  output reg         output_a_oe,
  output reg         output_b,
  output reg         output_b_oe,
  output reg         output_c,
  output reg         output_c_oe,
  output reg         output_d,
  output reg         output_d_oe,
  output wire        irq
);
  reg  [7:0]            shut_ctrl_reg;
  reg  [7:0]            gen_ctrl_reg;
  reg  [`IRQ_WIDTH-1:0] irq_status_reg;
  reg  [`IRQ_WIDTH-1:0] irq_mask_reg;
  reg                   aw_held_reg;
  reg  [3:0]            aw_addr_reg;
  reg                   w_held_reg;
  reg  [31:0]           w_data_reg;
  reg  [3:0]            w_strb_reg;
  reg                   outputs_shut_reg;
  reg                   data_prev_reg;
  reg                   pp_phase_reg;
  reg  [7:0]            shut_ctrl_next;
  wire                  deadband_done;
  wire                  data_rise;
  wire                  wr_fire;
  wire [3:0]            wr_addr;
  wire [31:0]           wr_data;
  wire [3:0]            wr_strb;
  wire                  wr_lane0;
  wire                  shut_flag;
  wire                  shut_entry;
  wire                  resume;
  wire                  gen_en;
  wire                  pp_a;
  wire                  pp_b;

  // Write address and data are each held until both are present; the response waits for both.
  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
  assign wr_addr  = aw_held_reg ? aw_addr_reg : s_axi_awaddr;
  assign wr_data  = w_held_reg ? w_data_reg : s_axi_wdata;
  assign wr_strb  = w_held_reg ? w_strb_reg : s_axi_wstrb;
  assign wr_fire  = (aw_held_reg || (s_axi_awvalid && s_axi_awready)) &&
                    (w_held_reg || (s_axi_wvalid && s_axi_wready));
  assign wr_lane0 = wr_fire && wr_strb[0];
  assign s_axi_arready = !s_axi_rvalid;

  assign shut_flag = shut_ctrl_reg[`BIT_SHUTDOWN];
  assign gen_en    = gen_ctrl_reg[`BIT_GEN_EN];
  assign data_rise = gen_data_in && !data_prev_reg;
  // A new event, or software setting the flag, enters shutdown.
  assign shut_entry = (shutdown_event && !shut_flag) ||
                      (wr_lane0 && (wr_addr == `ADDR_SHUTDOWN_CTRL) &&
                       wr_data[`BIT_SHUTDOWN] && !shut_flag);
  assign resume = outputs_shut_reg && !shut_flag && !shutdown_event && data_rise;

  // Write handshake capture and response channel.
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      aw_held_reg  <= 1'b0;
      aw_addr_reg  <= 4'h0;
      w_held_reg   <= 1'b0;
      w_data_reg   <= 32'h00000000;
      w_strb_reg   <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else begin
      if (wr_fire) begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_addr[1:0] == 2'h0) ? `RESP_OKAY : `RESP_SLVERR;
      end else begin
        if (s_axi_awvalid && s_axi_awready) begin
          aw_held_reg <= 1'b1;
          aw_addr_reg <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          w_held_reg <= 1'b1;
          w_data_reg <= s_axi_wdata;
          w_strb_reg <= s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
          s_axi_bvalid <= 1'b0;
        end
      end
    end
  end

  // Shutdown register next value: hardware set beats any software write, as does a restart clear.
  always @* begin
    shut_ctrl_next = shut_ctrl_reg;
    if (wr_lane0 && (wr_addr == `ADDR_SHUTDOWN_CTRL)) begin
      shut_ctrl_next[7:2] = wr_data[7:2];
    end
    if (shutdown_event) begin
      shut_ctrl_next[`BIT_SHUTDOWN] = 1'b1;
    end else if (shut_flag && shut_ctrl_reg[`BIT_RESTART_EN] && outputs_shut_reg) begin
      shut_ctrl_next[`BIT_SHUTDOWN] = 1'b0;
    end
    shut_ctrl_next[1:0] = 2'h0;
  end

  // Control, mask and sticky interrupt status registers.
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      shut_ctrl_reg  <= `SHUTDOWN_CTRL_RESET;
      gen_ctrl_reg   <= `GEN_CTRL_RESET;
      irq_status_reg <= {`IRQ_WIDTH{1'b0}};
      irq_mask_reg   <= {`IRQ_WIDTH{1'b0}};
    end else begin
      shut_ctrl_reg <= shut_ctrl_next;
      if (wr_lane0 && (wr_addr == `ADDR_GEN_CTRL)) begin
        gen_ctrl_reg <= wr_data[7:0];
      end
      if (wr_lane0 && (wr_addr == `ADDR_IRQ_MASK)) begin
        irq_mask_reg <= wr_data[`IRQ_WIDTH-1:0];
      end
      // Write-one-to-clear; a same-cycle event keeps its bit set.
      irq_status_reg <= (irq_status_reg &
                         ~((wr_lane0 && (wr_addr == `ADDR_IRQ_STATUS)) ?
                           wr_data[`IRQ_WIDTH-1:0] : {`IRQ_WIDTH{1'b0}})) |
                        {resume, shut_entry};
    end
  end

  assign irq = |(irq_status_reg & irq_mask_reg);

  // Read channel; unmapped offsets answer with an error and zero data.
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= (s_axi_araddr[1:0] == 2'h0) ? `RESP_OKAY : `RESP_SLVERR;
      case (s_axi_araddr)
        `ADDR_SHUTDOWN_CTRL: s_axi_rdata <= {24'h000000, shut_ctrl_reg};
        `ADDR_GEN_CTRL:      s_axi_rdata <= {24'h000000, gen_ctrl_reg};
        `ADDR_IRQ_STATUS:    s_axi_rdata <= {30'h00000000, irq_status_reg};
        `ADDR_IRQ_MASK:      s_axi_rdata <= {30'h00000000, irq_mask_reg};
        default:             s_axi_rdata <= 32'h00000000;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Output shutdown state; it lasts past the flag until the next data rise.
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      outputs_shut_reg <= 1'b0;
      data_prev_reg    <= 1'b0;
    end else begin
      data_prev_reg <= gen_data_in;
      if (shut_flag || shutdown_event) begin
        outputs_shut_reg <= 1'b1;
      end else if (resume) begin
        outputs_shut_reg <= 1'b0;
      end
    end
  end

  // Push-pull alternation; cleared while disabled or shut, and the rise that ends a shutdown
  // counts as the first pulse, so the resumed pulse goes to A.
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pp_phase_reg <= 1'b0;
    end else if (!gen_en || shutdown_event || (outputs_shut_reg && !resume)) begin
      pp_phase_reg <= 1'b0;
    end else if (data_rise) begin
      pp_phase_reg <= !pp_phase_reg;
    end
  end

  // On the rising cycle the phase has not flipped yet, so it is read inverted there.
  assign pp_a = data_rise ? !pp_phase_reg : (gen_data_in && pp_phase_reg);
  assign pp_b = gen_data_in && !pp_a;

  // A software-forced entry raises the flag a cycle before the outputs shut, so either keeps
  // the count running; otherwise that entry would never reach the inactive level.
  deadband_timer #(
    .CYCLES (DEADBAND_CYCLES),
    .WIDTH  (8)
  ) u_deadband (
    .core_clk (core_clk),
    .reset    (reset),
    .start    (shut_entry),
    .hold     (outputs_shut_reg || shut_flag),
    .done     (deadband_done)
  );

  // Pin drive. The inactive level is zero before polarity; before the dead-band ends the pair
  // keeps its normal drive, which trades a short overlap for never changing in mid dead-band.
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      output_a    <= 1'b0;
      output_b    <= 1'b0;
      output_c    <= 1'b0;
      output_d    <= 1'b0;
      output_a_oe <= 1'b0;
      output_b_oe <= 1'b0;
      output_c_oe <= 1'b0;
      output_d_oe <= 1'b0;
    end else if (outputs_shut_reg) begin
      case (shut_ctrl_reg[`FLD_AC_MSB:`FLD_AC_LSB])
        `STATE_DRIVE_HIGH: begin
          output_a    <= 1'b1;
          output_c    <= 1'b1;
          output_a_oe <= 1'b1;
          output_c_oe <= 1'b1;
        end
        `STATE_DRIVE_LOW: begin
          output_a    <= 1'b0;
          output_c    <= 1'b0;
          output_a_oe <= 1'b1;
          output_c_oe <= 1'b1;
        end
        `STATE_TRISTATE: begin
          output_a_oe <= 1'b0;
          output_c_oe <= 1'b0;
        end
        default: begin
          if (deadband_done) begin
            output_a    <= gen_ctrl_reg[`BIT_POL_A];
            output_c    <= gen_ctrl_reg[`BIT_POL_C];
            output_a_oe <= 1'b1;
            output_c_oe <= 1'b1;
          end
        end
      endcase
      case (shut_ctrl_reg[`FLD_BD_MSB:`FLD_BD_LSB])
        `STATE_DRIVE_HIGH: begin
          output_b    <= 1'b1;
          output_d    <= 1'b1;
          output_b_oe <= 1'b1;
          output_d_oe <= 1'b1;
        end
        `STATE_DRIVE_LOW: begin
          output_b    <= 1'b0;
          output_d    <= 1'b0;
          output_b_oe <= 1'b1;
          output_d_oe <= 1'b1;
        end
        `STATE_TRISTATE: begin
          output_b_oe <= 1'b0;
          output_d_oe <= 1'b0;
        end
        default: begin
          if (deadband_done) begin
            output_b    <= gen_ctrl_reg[`BIT_POL_B];
            output_d    <= gen_ctrl_reg[`BIT_POL_D];
            output_b_oe <= 1'b1;
            output_d_oe <= 1'b1;
          end
        end
      endcase
    end else if (gen_en) begin
      // Normal drive: half-bridge complement, or push-pull with C and D copying A and B.
      output_a    <= (gen_ctrl_reg[`BIT_PUSH_PULL] ? pp_a : gen_data_in) ^
                     gen_ctrl_reg[`BIT_POL_A];
      output_b    <= (gen_ctrl_reg[`BIT_PUSH_PULL] ? pp_b : !gen_data_in) ^
                     gen_ctrl_reg[`BIT_POL_B];
      output_c    <= (gen_ctrl_reg[`BIT_PUSH_PULL] ? pp_a : gen_data_in) ^
                     gen_ctrl_reg[`BIT_POL_C];
      output_d    <= (gen_ctrl_reg[`BIT_PUSH_PULL] ? pp_b : !gen_data_in) ^
                     gen_ctrl_reg[`BIT_POL_D];
      output_a_oe <= 1'b1;
      output_b_oe <= 1'b1;
      output_c_oe <= 1'b1;
      output_d_oe <= 1'b1;
    end else begin
      output_a_oe <= 1'b0;
      output_b_oe <= 1'b0;
      output_c_oe <= 1'b0;
      output_d_oe <= 1'b0;
    end
  end
endmodule // waveform_auto_shutdown_control
`default_nettype wire

// *** shared/shutdown_defines.vh ***
// Constants for the auto-shutdown control block: offsets, fields, resets, timing.
`ifndef SHUTDOWN_DEFINES_VH
`define SHUTDOWN_DEFINES_VH
`define ADDR_SHUTDOWN_CTRL     4'h0
`define ADDR_GEN_CTRL          4'h4
`define ADDR_IRQ_STATUS        4'h8
`define ADDR_IRQ_MASK          4'hC
`define ADDR_INDEX_MSB         3
`define ADDR_INDEX_LSB         2
`define BIT_SHUTDOWN           7
`define BIT_RESTART_EN         6
`define FLD_BD_MSB             5
`define FLD_BD_LSB             4
`define FLD_AC_MSB             3
`define FLD_AC_LSB             2
`define SHUTDOWN_CTRL_RESET    8'h14
`define BIT_GEN_EN             0
`define BIT_POL_A              1
`define BIT_POL_B              2
`define BIT_POL_C              3
`define BIT_POL_D              4
`define BIT_PUSH_PULL          5
`define GEN_CTRL_RESET         8'h00
`define IRQ_BIT_SHUTDOWN       0
`define IRQ_BIT_RESUME         1
`define IRQ_WIDTH              2
`define STATE_DRIVE_HIGH       2'h3
`define STATE_DRIVE_LOW        2'h2
`define STATE_TRISTATE         2'h1
`define STATE_INACTIVE         2'h0
`define DEADBAND_NS            50
`define CLK_PERIOD_NS          5
`define RESP_OKAY              2'h0
`define RESP_SLVERR            2'h2
`endif

// *** hw/deadband_timer.v ***
// Counts the dead-band interval that precedes the inactive-level shutdown state.
`timescale 1ns/10ps
`default_nettype none
module deadband_timer #(
  parameter CYCLES = 10,
  parameter WIDTH  = 8
) (
  input  wire core_clk,
  input  wire reset,
  input  wire start,
  input  wire hold,
  output reg  done
);
  reg [WIDTH-1:0] count_reg;

  // Restarted by each shutdown entry; done rises once the count is spent and stays while held.
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      count_reg <= {WIDTH{1'b0}};
      done      <= 1'b0;
    end else if (start) begin
      count_reg <= CYCLES[WIDTH-1:0];
      done      <= 1'b0;
    end else if (!hold) begin
      count_reg <= {WIDTH{1'b0}};
      done      <= 1'b0;
    end else if (count_reg != {WIDTH{1'b0}}) begin
      count_reg <= count_reg - {{(WIDTH-1){1'b0}}, 1'b1};
      done      <= (count_reg == {{(WIDTH-1){1'b0}}, 1'b1});
    end
  end
endmodule // deadband_timer
`default_nettype wire

// *** verification/shutdown_asserts.sv ***
// Checker for the bus handshakes and the shutdown hold of the auto-shutdown block.
`timescale 1ns/10ps
`default_nettype none
module shutdown_asserts #(
  parameter DEADBAND_CYCLES = 10
) (
  input wire logic        core_clk, reset, gen_data_in, shutdown_event,
  input wire logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
  input wire logic [3:0]  s_axi_awaddr,
  input wire logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_rvalid, s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        output_a, output_a_oe, output_b, output_b_oe,
  input wire logic        output_c, output_c_oe, output_d, output_d_oe
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  localparam int LIMIT = DEADBAND_CYCLES + 4;
  wire [7:0] pins = {output_a, output_a_oe, output_b, output_b_oe,
                     output_c, output_c_oe, output_d, output_d_oe};
  logic [7:0] hold_reg;
  logic       shut_reg;
  logic       data_q_reg;
  // Tracks a trip held past the dead-band; the count saturates so it cannot wrap.
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      hold_reg   <= 8'h00;
      shut_reg   <= 1'h0;
      data_q_reg <= 1'h0;
    end else begin
      data_q_reg <= gen_data_in;
      hold_reg   <= !shutdown_event ? 8'h00 : (hold_reg == 8'hFF ? hold_reg : hold_reg + 8'h01);
      if (hold_reg >= LIMIT)
        shut_reg <= 1'h1;
      else if (gen_data_in && !data_q_reg)
        shut_reg <= 1'h0;
    end
  end
  sequence write_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  chk_write_answer: assert property (write_taken |=> s_axi_bvalid)
    else $error("write response missing after a taken write");
  chk_misaligned_err: assert property (write_taken ##0 (s_axi_awaddr[1:0] != 2'h0)
    |=> s_axi_bresp == 2'h2) else $error("misaligned write not refused");
  chk_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped early");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data missing after a taken read");
  chk_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped early");
  chk_read_busy: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated after its handshake");
  chk_trip_forced: assert property (hold_reg > LIMIT |-> $stable(pins))
    else $error("pins moved during a held shutdown");
  chk_resume_wait: assert property (shut_reg && !(gen_data_in && !data_q_reg)
    |=> $stable(pins)) else $error("pins left shutdown without a data rise");
endmodule // shutdown_asserts
bind waveform_auto_shutdown_control shutdown_asserts #(.DEADBAND_CYCLES(DEADBAND_CYCLES)) u_chk (
  .core_clk(core_clk), .reset(reset), .gen_data_in(gen_data_in),
  .shutdown_event(shutdown_event), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_bresp(s_axi_bresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .output_a(output_a), .output_a_oe(output_a_oe), .output_b(output_b),
  .output_b_oe(output_b_oe), .output_c(output_c), .output_c_oe(output_c_oe),
  .output_d(output_d), .output_d_oe(output_d_oe));
`default_nettype wire

// *** verification/power_stage_model.sv ***
// Behavioural power stage: gate inputs with pull-downs and a latched fault comparator.
`timescale 1ns/10ps
`default_nettype none
module power_stage_model (
  input  wire logic       core_clk,
  input  wire logic       trip_cmd,
  input  wire logic [3:0] gate_value,
  input  wire logic [3:0] gate_enable,
  output var  logic       fault_out,
  output wire logic [3:0] gate_level
);
  initial fault_out = 1'h0;
  // The comparator is latched, so a trip reaches the block one edge late.
  always @(posedge core_clk) begin
    fault_out <= trip_cmd;
  end
  // A released gate falls to its pull-down rather than keeping its last level.
  assign gate_level = gate_value & gate_enable;
endmodule // power_stage_model
`default_nettype wire

// *** verification/testbench.sv ***
// Self-checking bench for the auto-shutdown control block.
`timescale 1ns/10ps
`default_nettype none
`include "shutdown_defines.vh"
module testbench;
  localparam int DB = 2;
  logic        core_clk = 1'h0, reset = 1'h1, gen_data_in = 1'h0, trip_cmd = 1'h0;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0, rd;
  logic [1:0]  rsp;
  logic        sa, sb;
  wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic   irq, shutdown_event;
  wire logic [1:0]  s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  wire logic [3:0]  val, oe, lvl;
  int n_errors = 0, cmp_count = 0;
  logic [31:0] ctl [4] = '{32'h6C, 32'h74, 32'h58, 32'h40};
  logic [31:0] gen [4] = '{32'h01, 32'h01, 32'h01, 32'h15};
  logic [7:0]  pin [4] = '{8'hAF, 8'h55, 8'h0A, 8'h5F};
  always #2.5 core_clk = ~core_clk;
  waveform_auto_shutdown_control #(.DEADBAND_CYCLES(DB)) dut (
    .core_clk(core_clk), .reset(reset), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .gen_data_in(gen_data_in), .shutdown_event(shutdown_event),
    .output_a(val[3]), .output_a_oe(oe[3]), .output_b(val[2]), .output_b_oe(oe[2]),
    .output_c(val[1]), .output_c_oe(oe[1]), .output_d(val[0]), .output_d_oe(oe[0]),
    .irq(irq));
  power_stage_model stage (.core_clk(core_clk), .trip_cmd(trip_cmd), .gate_value(val),
    .gate_enable(oe), .fault_out(shutdown_event), .gate_level(lvl));
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask
  // Each channel drops its valid once taken; the response is awaited, never timed.
  task automatic axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw, w, b;
    aw = 1'h0;
    w = 1'h0;
    b = 1'h0;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!b) begin
      @(posedge core_clk);
      aw = aw | s_axi_awready;
      w = w | s_axi_wready;
      b = s_axi_bvalid;
      r = s_axi_bresp;
      s_axi_awvalid <= !aw;
      s_axi_wvalid <= !w;
      s_axi_bready <= !b;
    end
  endtask
  task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar, got;
    ar = 1'h0;
    got = 1'h0;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    while (!got) begin
      @(posedge core_clk);
      ar = ar | s_axi_arready;
      got = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_arvalid <= !ar;
      s_axi_rready <= !got;
    end
  endtask
  task automatic reg_check(input string name, input logic [3:0] a, input logic [31:0] exp);
    axi_read(a, rd, rsp);
    check(name, rd, exp);
  endtask
  // The trip line passes through the stage's latch, so waits leave a margin.
  task automatic trip(input logic on, input int k);
    @(posedge core_clk);
    trip_cmd <= on;
    repeat (k) @(posedge core_clk);
    #1;
  endtask
  // One data pulse; records whether A or B drove high at any point of it.
  task automatic pulse(output logic pa, output logic pb);
    pa = 1'h0;
    pb = 1'h0;
    @(posedge core_clk);
    gen_data_in <= 1'h1;
    repeat (10) begin
      @(posedge core_clk);
      pa = pa | lvl[3];
      pb = pb | lvl[2];
    end
    gen_data_in <= 1'h0;
    repeat (10) @(posedge core_clk);
  endtask
  task automatic end_of_test();
    $display("counts: %0d compares, %0d mismatches", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Watchdog: the whole sequence needs well under a tenth of this span.
  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    end_of_test();
  end
  // Main sequence: register map, forced states, manual clear, sequencer restart.
  initial begin
    repeat (20) @(posedge core_clk);
    reset <= 1'h0;
    reg_check("ctrl", `ADDR_SHUTDOWN_CTRL, 32'h14);
    reg_check("gen", `ADDR_GEN_CTRL, 32'h0);
    reg_check("status", `ADDR_IRQ_STATUS, 32'h0);
    reg_check("mask", `ADDR_IRQ_MASK, 32'h0);
    check("oe", oe, 4'h0);
    axi_write(4'h1, 32'hFF, rsp);
    check("bresp", rsp, `RESP_SLVERR);
    axi_read(4'h2, rd, rsp);
    check("rresp", rsp, `RESP_SLVERR);
    reg_check("ctrl", `ADDR_SHUTDOWN_CTRL, 32'h14);
    $display("test register_map done");
    axi_write(`ADDR_IRQ_MASK, 32'h1, rsp);
    for (int i = 0; i < 4; i++) begin
      axi_write(`ADDR_GEN_CTRL, gen[i], rsp);
      axi_write(`ADDR_SHUTDOWN_CTRL, ctl[i], rsp);
      trip(1'h1, DB + 6);
      check("pins", {lvl, oe}, pin[i]);
      reg_check("flag", `ADDR_SHUTDOWN_CTRL, ctl[i] | 32'h80);
      check("irq", irq, 1'h1);
      trip(1'h0, 4);
      reg_check("flag", `ADDR_SHUTDOWN_CTRL, ctl[i]);
      check("held", {lvl, oe}, pin[i]);
      pulse(sa, sb);
      check("oe", oe, 4'hF);
      reg_check("status", `ADDR_IRQ_STATUS, 32'h3);
      axi_write(`ADDR_IRQ_STATUS, 32'h1, rsp);
      check("irq", irq, 1'h0);
      reg_check("status", `ADDR_IRQ_STATUS, 32'h2);
      axi_write(`ADDR_IRQ_STATUS, 32'h2, rsp);
    end
    $display("test forced_states done");
    axi_write(`ADDR_GEN_CTRL, 32'h01, rsp);
    axi_write(`ADDR_SHUTDOWN_CTRL, 32'h2C, rsp);
    trip(1'h1, DB + 6);
    trip(1'h0, 4);
    reg_check("flag", `ADDR_SHUTDOWN_CTRL, 32'hAC);
    pulse(sa, sb);
    check("held", {lvl, oe}, 8'hAF);
    axi_write(`ADDR_SHUTDOWN_CTRL, 32'h2C, rsp);
    reg_check("flag", `ADDR_SHUTDOWN_CTRL, 32'h2C);
    pulse(sa, sb);
    check("oe", oe, 4'hF);
    $display("test manual_clear done");
    axi_write(`ADDR_GEN_CTRL, 32'h00, rsp);
    axi_write(`ADDR_GEN_CTRL, 32'h21, rsp);
    pulse(sa, sb);
    check("first", {sa, sb}, 2'h2);
    axi_write(`ADDR_SHUTDOWN_CTRL, 32'h40, rsp);
    trip(1'h1, DB + 6);
    trip(1'h0, 4);
    pulse(sa, sb);
    if (!sa && !sb)
      pulse(sa, sb);
    check("restart", {sa, sb}, 2'h2);
    pulse(sa, sb);
    check("second", {sa, sb}, 2'h1);
    $display("test push_pull done");
    end_of_test();
  end
endmodule // testbench
`default_nettype wire
